/* etb_pkg.sv */
package etb_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ETB_OFS_DIV_HIGH = 8'h00;
   localparam logic [7:0] ETB_OFS_DIV_LOW  = 8'h04;
   localparam logic [7:0] ETB_OFS_NV_HIGH  = 8'h08;
   localparam logic [7:0] ETB_OFS_NV_LOW   = 8'h0C;
   localparam logic [7:0] ETB_OFS_CONFIG   = 8'h10;
   localparam logic [7:0] ETB_OFS_NV_CMD   = 8'h14;
   localparam logic [7:0] ETB_OFS_STATUS   = 8'h18;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int         ETB_DIV_W       = 11;
   localparam int         ETB_SECD_BIT    = 7;
   localparam logic [7:0] ETB_NV_ERASED   = 8'hFF;
   localparam logic [1:0] ETB_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ETB_RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int ETB_CLK_NS      = 100;
   localparam int ETB_TICK_NS     = 35000;
   localparam int ETB_BURN_MS     = 10;
   localparam int ETB_BURN_TICKS  =
      (ETB_BURN_MS * 1000000 + ETB_TICK_NS - 1) / ETB_TICK_NS;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ETB_OP_NONE    = 2'b00,
      ETB_OP_ERASE   = 2'b01,
      ETB_OP_PROGRAM = 2'b10
   } etb_op_t;

   typedef enum logic [0:0] {
      ETB_IDLE = 1'b0,
      ETB_BURN = 1'b1
   } etb_state_t;

   typedef enum logic [2:0] {
      ETB_R_DIV_HIGH = 3'b000,
      ETB_R_DIV_LOW  = 3'b001,
      ETB_R_NV_HIGH  = 3'b010,
      ETB_R_NV_LOW   = 3'b011,
      ETB_R_CONFIG   = 3'b100,
      ETB_R_NV_CMD   = 3'b101,
      ETB_R_STATUS   = 3'b110,
      ETB_R_NONE     = 3'b111
   } etb_reg_t;

   typedef struct packed {
      logic [7:0] data;
      logic [4:0] spare;
      logic       target_low;
      etb_op_t    op;
   } etb_nvcmd_t;

endpackage

/* etb_divider.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// [RULE1] Selected reference divided by divisor gives the 35 us timebase tick.
// [RULE2] Config bit selects crystal reference or bus clock as divider input.
// [RULE3] Software loads a proper divisor before any erase or program.
// [RULE4] Software reprograms the divisor after changing the reference clock.
// [RULE5] Reset copies both nonvolatile shadows into the volatile divider registers.
// [RULE6] Divisor is 11 bits: three in high register, eight in low.
// [RULE7] Software computes divisor as INT(freq times 35e-6 plus 0.5).
// [RULE8] Security disable bit: 1 means disabled, 0 means enabled.
// [RULE9] With security enabled both volatile registers, secd included, are locked.
// [RULE10] With security enabled shadow erase and program are refused.
// [RULE11] The eleven divisor bits read back at all times.
// [RULE12] Divisor writes act only with latch clear and secd one.
// [RULE13] Shadows hold reset values and keep them across system reset.
// [RULE14] Shadows erase and program like EEPROM bytes while secd is one.
// [RULE15] New shadow contents reach volatile registers only at next reset.
// [RULE16] Shadow secd programmed to 0 makes every reset load 0.
// [RULE17] Reference clock recommended between 250 kHz and 32 MHz.
// [RULE18] Byte program lasts at least 10 ms.
// [RULE19] Byte, block or bulk erase lasts at least 10 ms.
// [RULE20] Allow 100 us voltage discharge after program or erase.
// [RULE21] Wait 600 us after re-enable or stop before using EEPROM.
// [RULE22] When registers are not implemented, writes have no effect.
// [RULE23] Count reference cycles, tick when count reaches divisor, restart.
// [RULE24] Latch bit set during program or erase blocks divisor writes.
module etb_divider #(
   parameter logic P_FUTURE_REGS = 1'b1
) (
   // Clock and resets
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_por_b,
   // Reference clock pulses
   input  wire logic        i_crystal_ref_clock,
   input  wire logic        i_bus_clock,
   // AXI4-Lite write
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output      logic        o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output      logic        o_wready,
   output      logic [1:0]  o_bresp,
   output      logic        o_bvalid,
   input  wire logic        i_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output      logic        o_arready,
   output      logic [31:0] o_rdata,
   output      logic [1:0]  o_rresp,
   output      logic        o_rvalid,
   input  wire logic        i_rready,
   // Timebase and status
   output      logic        o_timebase_tick,
   output      logic        o_eeprom_latch_bit,
   output      logic        o_security_enabled
);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic etb_pkg::etb_reg_t etb_decode(input logic [7:0] a);
      if (a == etb_pkg::ETB_OFS_DIV_HIGH)
         etb_decode = etb_pkg::ETB_R_DIV_HIGH;
      else if (a == etb_pkg::ETB_OFS_DIV_LOW)
         etb_decode = etb_pkg::ETB_R_DIV_LOW;
      else if (a == etb_pkg::ETB_OFS_NV_HIGH)
         etb_decode = etb_pkg::ETB_R_NV_HIGH;
      else if (a == etb_pkg::ETB_OFS_NV_LOW)
         etb_decode = etb_pkg::ETB_R_NV_LOW;
      else if (a == etb_pkg::ETB_OFS_CONFIG)
         etb_decode = etb_pkg::ETB_R_CONFIG;
      else if (a == etb_pkg::ETB_OFS_NV_CMD)
         etb_decode = etb_pkg::ETB_R_NV_CMD;
      else if (a == etb_pkg::ETB_OFS_STATUS)
         etb_decode = etb_pkg::ETB_R_STATUS;
      else
         etb_decode = etb_pkg::ETB_R_NONE;
   endfunction

   // ------------------------------------------------------------
   // Reset synchroniser
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [etb_pkg::ETB_DIV_W-1:0] divisor;
   logic [etb_pkg::ETB_DIV_W-1:0] ref_count;
   logic [8:0]                    burn_count;
   logic [7:0]                    nv_high;
   logic [7:0]                    nv_low;
   logic                          secd;
   logic                          clock_select;
   logic                          load_pend;
   logic                          refused;
   logic                          aw_got;
   logic                          w_got;
   logic [7:0]                    aw_addr;
   logic [31:0]                   w_data;
   logic [3:0]                    w_strb;
   etb_pkg::etb_state_t           state;
   etb_pkg::etb_nvcmd_t           cmd;

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   wire etb_pkg::etb_reg_t   wr_reg   = etb_decode(aw_addr);
   wire etb_pkg::etb_reg_t   rd_reg   = etb_decode(i_araddr);
   wire etb_pkg::etb_nvcmd_t wr_cmd   = w_data[15:0];
   wire logic wr_fire  = aw_got & w_got & ~o_bvalid;
   wire logic lane0    = w_strb[0];
   wire logic div_ok   = P_FUTURE_REGS & ~o_eeprom_latch_bit & secd;   // [RULE12] [RULE22]
   wire logic wr_high  = wr_fire & lane0 & div_ok
                         & (wr_reg == etb_pkg::ETB_R_DIV_HIGH);        // [RULE9]
   wire logic wr_low   = wr_fire & lane0 & div_ok
                         & (wr_reg == etb_pkg::ETB_R_DIV_LOW);         // [RULE9]
   wire logic wr_cfg   = wr_fire & lane0 & P_FUTURE_REGS
                         & (wr_reg == etb_pkg::ETB_R_CONFIG);
   wire logic is_cmd   = wr_fire & (wr_reg == etb_pkg::ETB_R_NV_CMD);
   wire logic cmd_op   = wr_cmd.op != etb_pkg::ETB_OP_NONE;
   wire logic cmd_ok   = is_cmd & (&w_strb[1:0]) & cmd_op & div_ok;    // [RULE10] [RULE14]
   wire logic cmd_bad  = is_cmd & ~cmd_ok;
   wire logic ref_tick = clock_select ? i_bus_clock
                                      : i_crystal_ref_clock;           // [RULE2]
   wire logic [etb_pkg::ETB_DIV_W-1:0] next_ref_count =
      ref_count + 11'h001;
   wire logic burn_done = o_timebase_tick
      & (burn_count == 9'(etb_pkg::ETB_BURN_TICKS - 1));               // [RULE18] [RULE19]
   wire logic [7:0] burn_val =
      (cmd.op == etb_pkg::ETB_OP_ERASE) ? etb_pkg::ETB_NV_ERASED
      : ((cmd.target_low ? nv_low : nv_high) & cmd.data);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   wire logic [7:0] rd_byte =
      (rd_reg == etb_pkg::ETB_R_DIV_HIGH) ? {secd, 4'h0, divisor[10:8]}
      : (rd_reg == etb_pkg::ETB_R_DIV_LOW) ? divisor[7:0]              // [RULE11]
      : (rd_reg == etb_pkg::ETB_R_NV_HIGH) ? nv_high
      : (rd_reg == etb_pkg::ETB_R_NV_LOW) ? nv_low
      : (rd_reg == etb_pkg::ETB_R_CONFIG) ? {7'h00, clock_select}
      : (rd_reg == etb_pkg::ETB_R_STATUS)
         ? {5'h00, ~secd, refused, o_eeprom_latch_bit}
      : 8'h00;
   wire logic [1:0] rd_resp = (rd_reg == etb_pkg::ETB_R_NONE)
      ? etb_pkg::ETB_RESP_SLVERR : etb_pkg::ETB_RESP_OKAY;

   // ------------------------------------------------------------
   // AXI write channels
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         aw_addr   <= 8'h00;
         w_data    <= 32'h0000_0000;
         w_strb    <= 4'h0;
      end
      else
      begin
         if (o_awready & i_awvalid)
         begin
            o_awready <= 1'b0;
            aw_got    <= 1'b1;
            aw_addr   <= i_awaddr;
         end
         else if (o_bvalid & i_bready)
            aw_got <= 1'b0;
         else if (!aw_got & !o_bvalid & !load_pend)
            o_awready <= 1'b1;
         if (o_wready & i_wvalid)
         begin
            o_wready <= 1'b0;
            w_got    <= 1'b1;
            w_data   <= i_wdata;
            w_strb   <= i_wstrb;
         end
         else if (o_bvalid & i_bready)
            w_got <= 1'b0;
         else if (!w_got & !o_bvalid & !load_pend)
            o_wready <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         o_bvalid <= 1'b0;
         o_bresp  <= etb_pkg::ETB_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         o_bvalid <= 1'b1;
         o_bresp  <= (wr_reg == etb_pkg::ETB_R_NONE)
                     ? etb_pkg::ETB_RESP_SLVERR : etb_pkg::ETB_RESP_OKAY;
      end
      else if (i_bready)
         o_bvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // AXI read channels
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= etb_pkg::ETB_RESP_OKAY;
      end
      else if (o_arready & i_arvalid)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= {24'h00_0000, rd_byte};
         o_rresp   <= rd_resp;
      end
      else if (o_rvalid & i_rready)
         o_rvalid <= 1'b0;
      else if (!o_rvalid & !load_pend)
         o_arready <= 1'b1;
   end

   // ------------------------------------------------------------
   // Volatile divider registers
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         load_pend    <= 1'b1;
         divisor      <= 11'h000;
         secd         <= 1'b0;
         clock_select <= 1'b0;
      end
      else
      begin
         if (load_pend)
         begin
            load_pend <= 1'b0;
            divisor   <= {nv_high[2:0], nv_low};                    // [RULE5] [RULE15]
            secd      <= nv_high[etb_pkg::ETB_SECD_BIT];            // [RULE16]
         end
         if (wr_high)
         begin
            divisor[10:8] <= w_data[2:0];                           // [RULE6]
            secd          <= w_data[etb_pkg::ETB_SECD_BIT];         // [RULE8]
         end
         if (wr_low)
            divisor[7:0] <= w_data[7:0];                            // [RULE6]
         if (wr_cfg)
            clock_select <= w_data[0];
      end
   end

   // ------------------------------------------------------------
   // Timebase divider
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         ref_count       <= 11'h000;
         o_timebase_tick <= 1'b0;
      end
      else
      begin
         o_timebase_tick <= 1'b0;
         if (ref_tick)
         begin
            if ((divisor != 11'h000) && (next_ref_count >= divisor))
            begin
               ref_count       <= 11'h000;                          // [RULE23]
               o_timebase_tick <= 1'b1;                             // [RULE1]
            end
            else
               ref_count <= next_ref_count;                         // [RULE23]
         end
      end
   end

   // ------------------------------------------------------------
   // Shadow erase and program sequencer
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         state              <= etb_pkg::ETB_IDLE;
         cmd                <= '0;
         burn_count         <= 9'h000;
         refused            <= 1'b0;
         o_eeprom_latch_bit <= 1'b0;
      end
      else
      begin
         case (state)
            etb_pkg::ETB_IDLE:
            begin
               if (cmd_ok)
               begin
                  cmd                <= wr_cmd;
                  burn_count         <= 9'h000;
                  refused            <= 1'b0;
                  o_eeprom_latch_bit <= 1'b1;                       // [RULE24]
                  state              <= etb_pkg::ETB_BURN;
               end
               else if (cmd_bad)
                  refused <= 1'b1;                                  // [RULE10]
            end
            etb_pkg::ETB_BURN:
            begin
               if (cmd_bad)
                  refused <= 1'b1;
               if (burn_done)
               begin
                  o_eeprom_latch_bit <= 1'b0;                       // [RULE24]
                  state              <= etb_pkg::ETB_IDLE;
               end
               else if (o_timebase_tick)
                  burn_count <= burn_count + 9'h001;
            end
            default:
               state <= etb_pkg::ETB_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Nonvolatile shadows, cleared only at power-on
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_por_b)
   begin
      if (!i_por_b)
      begin
         nv_high <= etb_pkg::ETB_NV_ERASED;
         nv_low  <= etb_pkg::ETB_NV_ERASED;
      end
      else if ((state == etb_pkg::ETB_BURN) && burn_done)
      begin
         if (cmd.target_low)
            nv_low <= burn_val;                                     // [RULE14]
         else
            nv_high <= burn_val;                                    // [RULE14]
      end
   end

   // ------------------------------------------------------------
   // Security status
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_sync)
   begin
      if (!rst_sync)
         o_security_enabled <= 1'b0;
      else
         o_security_enabled <= ~secd & ~load_pend;                  // [RULE8]
   end

endmodule // etb_divider

/* etb_divider_asserts.sv */
`timescale 1ns/1ns
module etb_divider_asserts (
   // Clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_rst_b,
   // Observed ports
   input wire logic        i_crystal_ref_clock,
   input wire logic        i_bus_clock,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic        o_rvalid,
   input wire logic        o_awready,
   input wire logic        o_wready,
   input wire logic [1:0]  o_bresp,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic        o_timebase_tick,
   input wire logic        o_eeprom_latch_bit,
   input wire logic        o_security_enabled
);
   // --------
   // Ticks seen during a burn
   // --------
   logic [9:0] burn_ticks;

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
      if (!i_rst_b)
         burn_ticks <= 10'h000;
      else if (!o_eeprom_latch_bit)
         burn_ticks <= 10'h000;
      else if (o_timebase_tick)
         burn_ticks <= burn_ticks + 10'h001;

   // --------
   // Assertions
   // --------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   a_tick_cause:
      assert property (o_timebase_tick |-> $past(i_crystal_ref_clock | i_bus_clock))
      else $error("tick without reference pulse");
   a_secure_sticky:
      assert property (o_security_enabled |=> o_security_enabled)
      else $error("security lock released");
   a_latch_needs_secd:
      assert property ($rose(o_eeprom_latch_bit) |-> !o_security_enabled)
      else $error("burn started while locked");
   a_latch_with_resp:
      assert property ($rose(o_eeprom_latch_bit) |-> $rose(o_bvalid))
      else $error("latch rise not with write response");
   a_burn_length:
      assert property ($fell(o_eeprom_latch_bit) |->
         burn_ticks + 10'h001 >= etb_pkg::ETB_BURN_TICKS
         && burn_ticks <= etb_pkg::ETB_BURN_TICKS + 1)
      else $error("burn length wrong");
   a_read_answer:
      assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read answer late");
   a_rdata_narrow:
      assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_b_release:
      assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write response held");
   a_wr_quiet:
      assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write ready during response");

   c_burn_done: cover property ($fell(o_eeprom_latch_bit));
   c_locked: cover property ($rose(o_security_enabled));
   c_slverr: cover property (o_bvalid && o_bresp == etb_pkg::ETB_RESP_SLVERR);
endmodule // etb_divider_asserts

/* test_etb_divider.sv */
`timescale 1ns/1ns
module test_etb_divider;
   // --------
   // Signals and model state
   // --------
   localparam logic [1:0] OK  = etb_pkg::ETB_RESP_OKAY;
   localparam logic [1:0] ERR = etb_pkg::ETB_RESP_SLVERR;
   logic        i_ref_clk, i_rst_b, i_por_b, i_crystal_ref_clock, i_bus_clock;
   logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic        o_timebase_tick, o_eeprom_latch_bit, o_security_enabled;
   logic [7:0]  i_awaddr, i_araddr;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp;
   logic [31:0] i_wdata, o_rdata;
   logic [31:0] rnd = 32'h85AF42A7;
   int          error_cnt, total_checks, div, secd, nvh, nvl, sel, refused, cnt;
   bit          mon_on, synced, pmode;

   etb_divider etb_divider_i (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b),
      .i_crystal_ref_clock(i_crystal_ref_clock), .i_bus_clock(i_bus_clock),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .o_timebase_tick(o_timebase_tick), .o_eeprom_latch_bit(o_eeprom_latch_bit),
      .o_security_enabled(o_security_enabled)
   );

   // --------
   // Helpers
   // --------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      @(negedge i_ref_clk);
      while (!(o_awready && o_wready)) @(negedge i_ref_clk);
      @(posedge i_ref_clk);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      @(negedge i_ref_clk);
      while (!o_bvalid) @(negedge i_ref_clk);
      chk("bresp", o_bresp, er);
      @(posedge i_ref_clk);
      i_bready <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge i_ref_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      @(negedge i_ref_clk);
      while (!o_arready) @(negedge i_ref_clk);
      @(posedge i_ref_clk);
      i_arvalid <= 1'b0;
      @(negedge i_ref_clk);
      while (!o_rvalid) @(negedge i_ref_clk);
      chk($sformatf("rdata %h", a), o_rdata, e);
      chk("rresp", o_rresp, er);
      @(posedge i_ref_clk);
      i_rready <= 1'b0;
   endtask

   task automatic check_all();
      rdc(etb_pkg::ETB_OFS_DIV_HIGH, secd * 128 + div / 256, OK);
      rdc(etb_pkg::ETB_OFS_DIV_LOW, div % 256, OK);
      rdc(etb_pkg::ETB_OFS_NV_HIGH, nvh, OK);
      rdc(etb_pkg::ETB_OFS_NV_LOW, nvl, OK);
      rdc(etb_pkg::ETB_OFS_CONFIG, sel, OK);
      rdc(etb_pkg::ETB_OFS_STATUS, (1 - secd) * 4 + refused * 2, OK);
      chk("security pin", o_security_enabled, 1 - secd);
      chk("latch pin", o_eeprom_latch_bit, 0);
   endtask

   task automatic setdiv(input int d);
      wrc(etb_pkg::ETB_OFS_DIV_LOW, d % 256, OK);
      wrc(etb_pkg::ETB_OFS_DIV_HIGH, 128 + d / 256, OK);
      div = d;
   endtask

   task automatic burn(input etb_pkg::etb_op_t op, input logic tl, input logic [7:0] v);
      etb_pkg::etb_nvcmd_t c;
      c = 16'h0000;
      c.op = op;
      c.target_low = tl;
      c.data = v;
      wrc(etb_pkg::ETB_OFS_NV_CMD, {16'h0000, c}, OK);
      refused = (secd == 0 || op == etb_pkg::ETB_OP_NONE || i_wstrb[1:0] != 2'b11);
      if (!refused)
      begin
         rdc(etb_pkg::ETB_OFS_STATUS, 32'h00000001, OK);
         wrc(etb_pkg::ETB_OFS_DIV_LOW, 32'h000000AA, OK);
         while (o_eeprom_latch_bit) @(posedge i_ref_clk);
         repeat (1000) @(posedge i_ref_clk); // 100 us discharge
         if (tl) nvl = (op == etb_pkg::ETB_OP_ERASE) ? 255 : nvl & v;
         else nvh = (op == etb_pkg::ETB_OP_ERASE) ? 255 : nvh & v;
      end
      check_all();
   endtask

   task automatic do_reset(input bit por);
      @(posedge i_ref_clk);
      i_rst_b <= 1'b0;
      i_por_b <= !por;
      repeat (8) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      i_por_b <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      repeat (6000) @(posedge i_ref_clk); // 600 us recovery
      if (por) nvh = 255;
      if (por) nvl = 255;
      div = (nvh % 8) * 256 + nvl;
      secd = nvh / 128;
      sel = 0;
      refused = 0;
   endtask

   // --------
   // Clock, reference pulses, tick monitor, watchdog
   // --------
   initial
   begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk)
   begin
      rnd <= lfsr(rnd);
      i_crystal_ref_clock <= pmode | rnd[3]; // at most 10 MHz
      i_bus_clock <= pmode | rnd[7];
   end

   always @(posedge i_ref_clk)
      if (mon_on)
      begin
         if (o_timebase_tick)
         begin
            if (synced) chk("tick period", cnt, div);
            synced = 1;
            cnt = 0;
         end
         if (sel ? i_bus_clock : i_crystal_ref_clock)
            cnt++;
      end

   initial
   begin
      repeat (40000) @(posedge i_ref_clk);
      error_cnt++;
      summarize();
   end

   // --------
   // Main sequence
   // --------
   initial
   begin
      {i_rst_b, i_por_b, i_crystal_ref_clock, i_bus_clock} = 4'h0;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      i_awaddr = 8'h00;
      i_araddr = 8'h00;
      i_wdata = 32'h00000000;
      i_wstrb = 4'hF;
      do_reset(1'b1);
      check_all();
      rdc(8'h1C, 32'h00000000, ERR);
      wrc(8'h1C, 32'h000000FF, ERR);
      burn(etb_pkg::ETB_OP_NONE, 1'b0, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         mon_on = 0;
         pmode = (k == 2);
         sel = (k == 1);
         wrc(etb_pkg::ETB_OFS_CONFIG, sel, OK);
         setdiv(k == 2 ? 350 : 2 + rnd[4:0]); // 350 pulses at 10 MHz
         check_all();
         synced = 0;
         mon_on = 1;
         repeat (k == 2 ? 1000 : 300) @(posedge i_ref_clk);
      end
      mon_on = 0;
      setdiv(1);
      burn(etb_pkg::ETB_OP_ERASE, 1'b1, 8'h00);
      burn(etb_pkg::ETB_OP_PROGRAM, 1'b1, 8'h5A);
      burn(etb_pkg::ETB_OP_PROGRAM, 1'b0, 8'h03);
      i_wstrb <= 4'h1;
      burn(etb_pkg::ETB_OP_ERASE, 1'b0, 8'h00); // half strobe refused
      i_wstrb <= 4'hF;
      do_reset(1'b0);
      check_all();
      wrc(etb_pkg::ETB_OFS_DIV_LOW, 32'h00000011, OK);
      wrc(etb_pkg::ETB_OFS_DIV_HIGH, 32'h00000087, OK);
      burn(etb_pkg::ETB_OP_ERASE, 1'b0, 8'h00);
      do_reset(1'b0);
      check_all();
      summarize();
   end
endmodule // test_etb_divider

bind etb_divider etb_divider_asserts etb_divider_asserts_i (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_crystal_ref_clock(i_crystal_ref_clock),
   .i_bus_clock(i_bus_clock), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_awready(o_awready), .o_wready(o_wready),
   .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .o_timebase_tick(o_timebase_tick), .o_eeprom_latch_bit(o_eeprom_latch_bit),
   .o_security_enabled(o_security_enabled)
);
